// ===== sbc_cfg.svh
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

// page select register: offset, reset value and field positions
`define SBC_PAGE_ADDR      8'hff
`define SBC_PAGE_RST       8'h00
`define SBC_PG_CHAN_LO     0
`define SBC_PG_CHAN_HI     1
`define SBC_PG_ROUTE       2
`define SBC_PG_BCAST       3

// register sets: one shared set plus four channel sets
`define SBC_NSETS          5
`define SBC_SET_DEPTH      256

// slave write address for strap 00, others step by two
`define SBC_WR_ADDR_BASE   8'h30

// boot fetch from the configuration memory
`define SBC_EE_DEV_WR      8'ha0
`define SBC_EE_DEV_RD      8'ha1
`define SBC_EE_START_WORD  8'h00
`define SBC_BOOT_PAIRS     16

// timing: clock period and fastest serial clock of the boot memory
`define SBC_CLK_NS         100
`define SBC_EE_MAX_KHZ     520

`endif

// ===== sbc_pkg.sv
package sbc_pkg;

  // three level control mode strap
  typedef enum logic [1:0] {
    MODE_PIN   = 2'h0,
    MODE_BOOT  = 2'h1,
    MODE_SLAVE = 2'h2
  } sbc_mode_t;

  // slave byte engine states
  typedef enum logic [5:0] {
    SL_IDLE = 6'h01,
    SL_ADDR = 6'h02,
    SL_RX   = 6'h04,
    SL_SLOT = 6'h08,
    SL_TX   = 6'h10,
    SL_TACK = 6'h20
  } sbc_sl_t;

  // boot master states
  typedef enum logic [5:0] {
    M_OFF   = 6'h01,
    M_WAIT  = 6'h02,
    M_START = 6'h04,
    M_BIT   = 6'h08,
    M_STOP  = 6'h10,
    M_DONE  = 6'h20
  } sbc_ms_t;

endpackage

// ===== sbc_if.sv
`timescale 1ns/1ps

// bus line levels and detected events
interface sbc_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  modport src (output scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
  modport snk (input  scl, sda, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

// register set store access
interface sbc_mem_if;
  logic [4:0] we_mask;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [2:0] rset;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport host  (output we_mask, waddr, wdata, rset, raddr, input rdata);
  modport store (input we_mask, waddr, wdata, rset, raddr, output rdata);
endinterface

// ===== sbc_line_watch.sv
`timescale 1ns/1ps

module sbc_line_watch (
  input wire logic   clk,
  input wire logic   rst_b,
  input wire logic   scl_in,
  input wire logic   sda_in,
  sbc_line_if.src    lin
);

  typedef struct packed {
    logic scl;
    logic sda;
  } sbc_lw_st_t;

  sbc_lw_st_t st_reg;
  sbc_lw_st_t st_next;

  //////////////////////////////////////////////////////////////////////////
  // previous line levels
  always_comb begin
    st_next.scl = scl_in;
    st_next.sda = sda_in;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edges and start / stop conditions
  assign lin.scl        = scl_in;
  assign lin.sda        = sda_in;
  assign lin.scl_rise   = scl_in & ~st_reg.scl;
  assign lin.scl_fall   = ~scl_in & st_reg.scl;
  assign lin.start_seen = scl_in & st_reg.scl & st_reg.sda & ~sda_in;
  assign lin.stop_seen  = scl_in & st_reg.scl & ~st_reg.sda & sda_in;

endmodule // sbc_line_watch

// ===== sbc_reg_store.sv
`timescale 1ns/1ps
`include "sbc_cfg.svh"

module sbc_reg_store #(
  parameter int NSETS = `SBC_NSETS,
  parameter int DEPTH = `SBC_SET_DEPTH
) (
  input wire logic   clk,
  input wire logic   rst_b,
  sbc_mem_if.store   m
);

  typedef struct packed {
    logic [7:0] rdata;
  } sbc_rs_st_t;

  logic [7:0] mem [NSETS][DEPTH];
  sbc_rs_st_t st_reg;
  sbc_rs_st_t st_next;

  //////////////////////////////////////////////////////////////////////////
  // writes: each set whose mask bit is up takes the byte
  always_ff @(posedge clk) begin
    for (int s = 0; s < NSETS; s++) begin
      if (m.we_mask[s]) begin
        mem[s][m.waddr] <= m.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered read, out of range set reads zero
  always_comb begin
    st_next = st_reg;
    if (int'(m.rset) < NSETS) begin
      st_next.rdata = mem[m.rset][m.raddr];
    end else begin
      st_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign m.rdata = st_reg.rdata;

endmodule // sbc_reg_store

// ===== sbc_top.sv
`timescale 1ns/1ps
`include "sbc_cfg.svh"
// Operation
// - mode strap: high slave only, float memory boot master, low pin mode.
// - boot fetch starts only once fetch-allow input is sampled low.
// - after the fetch completes, boot-done output goes low and stays low.
// - master only during fetch, then bus released, slave only afterwards.
// - address straps latched once after each reset release; floating line reads 0.
// - straps 00..11 give write addresses 30,32,34,36; read is plus one.
// - address byte low bit gives direction: 0 write, 1 read.
// - write is start, address, register byte, data; every byte acknowledged.
// - writes to address ff always update the page select register.
// - page bit 2 routes later accesses to shared or channel set.
// - page bits 1:0 choose the channel set while channel routing.
// - page bits 3 and 2 both set broadcast writes to all channels.

module sbc_top #(
  parameter int BOOT_PAIRS = `SBC_BOOT_PAIRS
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic [1:0] CONTROL_MODE_STRAP,
  input  wire logic [1:0] ADDR_STRAP,
  input  wire logic       BOOT_FETCH_ALLOW_N,
  output wire logic       BOOT_DONE_N,
  input  wire logic       SCL_I,
  output wire logic       SCL_O,
  output wire logic       SCL_OE_B,
  input  wire logic       SDA_I,
  output wire logic       SDA_O,
  output wire logic       SDA_OE_B
);

  // quarter of a serial bit, rounded up so the clock never exceeds the limit
  localparam int CLK_NS  = `SBC_CLK_NS;
  localparam int EE_KHZ  = `SBC_EE_MAX_KHZ;
  localparam int QTR_CYC = (1000000 + 4 * EE_KHZ * CLK_NS - 1)
                           / (4 * EE_KHZ * CLK_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [9:0] LAST_IDX = 10'(2 + 2 * BOOT_PAIRS);

  typedef struct packed {
    logic              latched;
    sbc_pkg::sbc_mode_t mode;
    logic [1:0]        adr;
    logic [7:0]        page;
    logic              wr_en;
    logic [7:0]        wr_a;
    logic [7:0]        wr_d;
    sbc_pkg::sbc_sl_t  sl;
    logic [3:0]        scnt;
    logic [7:0]        ssh;
    logic [7:0]        ptr;
    logic              srd;
    logic              sfirst;
    logic              s_sda_low;
    sbc_pkg::sbc_ms_t  mst;
    logic [1:0]        q;
    logic [7:0]        qcnt;
    logic [3:0]        bitn;
    logic [9:0]        idx;
    logic [7:0]        mtx;
    logic [7:0]        mrx;
    logic [7:0]        maddr;
    logic              m_nack;
    logic              m_sda_low;
    logic              m_sda_pre;
    logic              m_scl_low;
    logic              done;
  } sbc_top_st_t;

  sbc_top_st_t st;
  sbc_top_st_t st_next;
  logic        slave_on;
  logic        tick;
  logic        writing;
  logic [7:0]  tx_load;
  logic [7:0]  slv_addr;

  sbc_line_if lin ();
  sbc_mem_if  mem_if ();

  //////////////////////////////////////////////////////////////////////////
  // write routing mask: shared, one channel, or all channels
  function automatic logic [4:0] route_mask(input logic [7:0] pg);
    if (!pg[`SBC_PG_ROUTE]) begin
      return 5'h01;
    end
    if (pg[`SBC_PG_BCAST]) begin
      return 5'h1e;
    end
    return 5'(5'h02 << pg[`SBC_PG_CHAN_HI:`SBC_PG_CHAN_LO]);
  endfunction

  // read set index for the current page
  function automatic logic [2:0] read_set(input logic [7:0] pg);
    if (pg[`SBC_PG_ROUTE]) begin
      return 3'({1'b0, pg[`SBC_PG_CHAN_HI:`SBC_PG_CHAN_LO]}) + 3'h1;
    end
    return 3'h0;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // helpers
  assign slave_on = st.latched && (st.mode == sbc_pkg::MODE_SLAVE ||
                    (st.mode == sbc_pkg::MODE_BOOT &&
                     st.mst == sbc_pkg::M_DONE));
  assign tick     = st.qcnt == QTR_LAST;
  assign writing  = st.idx <= 10'h002;
  assign tx_load  = (st.ptr == `SBC_PAGE_ADDR) ? st.page : mem_if.rdata;
  assign slv_addr = `SBC_WR_ADDR_BASE | {5'h00, st.adr, 1'b0};

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next       = st;
    st_next.wr_en = 1'b0;

    // straps caught once, on the first clock after reset release
    if (!st.latched) begin
      st_next.latched = 1'b1;
      st_next.mode    = sbc_pkg::sbc_mode_t'(CONTROL_MODE_STRAP);
      st_next.adr     = ADDR_STRAP;
    end

    // page select takes every write to its address
    if (st.wr_en && st.wr_a == `SBC_PAGE_ADDR) begin
      st_next.page = st.wr_d;
    end

    // slave byte engine
    if (!slave_on) begin
      st_next.sl        = sbc_pkg::SL_IDLE;
      st_next.s_sda_low = 1'b0;
    end else if (lin.start_seen) begin
      st_next.sl        = sbc_pkg::SL_ADDR;
      st_next.scnt      = 4'h0;
      st_next.sfirst    = 1'b1;
      st_next.s_sda_low = 1'b0;
    end else if (lin.stop_seen) begin
      st_next.sl        = sbc_pkg::SL_IDLE;
      st_next.s_sda_low = 1'b0;
    end else begin
      case (st.sl)
        sbc_pkg::SL_ADDR, sbc_pkg::SL_RX: begin
          if (lin.scl_rise && st.scnt != 4'h8) begin
            st_next.ssh  = {st.ssh[6:0], lin.sda};
            st_next.scnt = st.scnt + 4'h1;
          end else if (lin.scl_fall && st.scnt == 4'h8) begin
            st_next.sl        = sbc_pkg::SL_SLOT;
            st_next.s_sda_low = 1'b1;
            st_next.srd       = 1'b0;
            if (st.sl == sbc_pkg::SL_ADDR) begin
              if (st.ssh[7:1] == slv_addr[7:1]) begin
                st_next.srd = st.ssh[0];
              end else begin
                st_next.sl        = sbc_pkg::SL_IDLE;
                st_next.s_sda_low = 1'b0;
              end
            end else if (st.sfirst) begin
              st_next.ptr    = st.ssh;
              st_next.sfirst = 1'b0;
            end else begin
              st_next.wr_en = 1'b1;
              st_next.wr_a  = st.ptr;
              st_next.wr_d  = st.ssh;
              st_next.ptr   = st.ptr + 8'h01;
            end
          end
        end
        sbc_pkg::SL_SLOT: begin
          if (lin.scl_fall) begin
            if (st.srd) begin
              st_next.sl        = sbc_pkg::SL_TX;
              st_next.s_sda_low = ~tx_load[7];
              st_next.ssh       = {tx_load[6:0], 1'b0};
              st_next.scnt      = 4'h1;
            end else begin
              st_next.sl        = sbc_pkg::SL_RX;
              st_next.s_sda_low = 1'b0;
              st_next.scnt      = 4'h0;
            end
          end
        end
        sbc_pkg::SL_TX: begin
          if (lin.scl_fall) begin
            if (st.scnt == 4'h8) begin
              st_next.sl        = sbc_pkg::SL_TACK;
              st_next.s_sda_low = 1'b0;
              st_next.ptr       = st.ptr + 8'h01;
            end else begin
              st_next.s_sda_low = ~st.ssh[7];
              st_next.ssh       = {st.ssh[6:0], 1'b0};
              st_next.scnt      = st.scnt + 4'h1;
            end
          end
        end
        sbc_pkg::SL_TACK: begin
          // a nack from the host ends the read
          if (lin.scl_rise) begin
            st_next.sl = lin.sda ? sbc_pkg::SL_IDLE : sbc_pkg::SL_SLOT;
          end
        end
        sbc_pkg::SL_IDLE: begin
          st_next.s_sda_low = 1'b0;
        end
        default: begin
          st_next.sl        = sbc_pkg::SL_IDLE;
          st_next.s_sda_low = 1'b0;
        end
      endcase
    end

    // boot master quarter timer
    if (tick) begin
      st_next.qcnt = 8'h00;
      st_next.q    = st.q + 2'h1;
    end else begin
      st_next.qcnt = st.qcnt + 8'h01;
    end

    // boot master sequencer
    case (st.mst)
      sbc_pkg::M_OFF: begin
        if (st.latched && st.mode == sbc_pkg::MODE_BOOT) begin
          st_next.mst = sbc_pkg::M_WAIT;
        end
      end
      sbc_pkg::M_WAIT: begin
        st_next.qcnt = 8'h00;
        st_next.q    = 2'h0;
        if (!BOOT_FETCH_ALLOW_N) begin
          st_next.mst = sbc_pkg::M_START;
          st_next.idx = 10'h000;
          st_next.mtx = `SBC_EE_DEV_WR;
        end
      end
      sbc_pkg::M_START: begin
        if (tick && st.q == 2'h3) begin
          st_next.mst  = sbc_pkg::M_BIT;
          st_next.bitn = 4'h0;
        end
      end
      sbc_pkg::M_BIT: begin
        if (tick && st.q == 2'h2) begin
          if (st.bitn == 4'h8) begin
            st_next.m_nack = SDA_I;
          end else begin
            st_next.mrx = {st.mrx[6:0], SDA_I};
          end
        end
        if (tick && st.q == 2'h3) begin
          st_next.bitn = st.bitn + 4'h1;
          if (st.bitn != 4'h8) begin
            if (writing) begin
              st_next.mtx = {st.mtx[6:0], 1'b0};
            end
          end else begin
            st_next.bitn = 4'h0;
            st_next.idx  = st.idx + 10'h001;
            if (writing && st.m_nack) begin
              st_next.mst = sbc_pkg::M_STOP; // missing memory ends fetch
            end else if (st.idx == 10'h000) begin
              st_next.mtx = `SBC_EE_START_WORD;
            end else if (st.idx == 10'h001) begin
              st_next.mst = sbc_pkg::M_START;
              st_next.mtx = `SBC_EE_DEV_RD;
            end else if (!writing) begin
              // odd index holds a register address, even its data
              if (st.idx[0]) begin
                st_next.maddr = st.mrx;
              end else begin
                st_next.wr_en = 1'b1;
                st_next.wr_a  = st.maddr;
                st_next.wr_d  = st.mrx;
              end
              if (st.idx == LAST_IDX) begin
                st_next.mst = sbc_pkg::M_STOP;
              end
            end
          end
        end
      end
      sbc_pkg::M_STOP: begin
        if (tick && st.q == 2'h3) begin
          st_next.mst  = sbc_pkg::M_DONE;
          st_next.done = 1'b1;
        end
      end
      sbc_pkg::M_DONE: begin
        st_next.done = 1'b1;
      end
      default: begin
        st_next.mst = sbc_pkg::M_OFF;
      end
    endcase

    // master line drive, low only while fetching
    case (st.mst)
      sbc_pkg::M_START: begin
        st_next.m_scl_low = st.q == 2'h0;
        st_next.m_sda_pre = st.q[1];
      end
      sbc_pkg::M_STOP: begin
        st_next.m_scl_low = st.q == 2'h0;
        st_next.m_sda_pre = ~st.q[1];
      end
      sbc_pkg::M_BIT: begin
        st_next.m_scl_low = ~st.q[1];
        if (writing) begin
          st_next.m_sda_pre = st.bitn != 4'h8 && !st.mtx[7];
        end else begin
          st_next.m_sda_pre = st.bitn == 4'h8 && st.idx != LAST_IDX;
        end
      end
      default: begin
        st_next.m_scl_low = 1'b0;
        st_next.m_sda_pre = 1'b0;
      end
    endcase
    // data moves one cycle after the clock falls, never on the same edge
    st_next.m_sda_low = st.m_sda_pre;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      st        <= '0;
      st.page   <= `SBC_PAGE_RST;
      st.sl     <= sbc_pkg::SL_IDLE;
      st.mst    <= sbc_pkg::M_OFF;
      st.mode   <= sbc_pkg::MODE_PIN;
    end else begin
      st <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // submodules and store access
  sbc_line_watch u_watch (
    .clk    (REF_CLK),
    .rst_b  (RST_B),
    .scl_in (SCL_I),
    .sda_in (SDA_I),
    .lin    (lin)
  );

  sbc_reg_store u_store (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .m     (mem_if)
  );

  assign mem_if.we_mask = (st.wr_en && st.wr_a != `SBC_PAGE_ADDR) ?
                          route_mask(st.page) : 5'h00;
  assign mem_if.waddr   = st.wr_a;
  assign mem_if.wdata   = st.wr_d;
  assign mem_if.rset    = read_set(st.page);
  assign mem_if.raddr   = st.ptr;

  // open drain pins: drive low only, enable active low
  assign SCL_O       = 1'b0;
  assign SDA_O       = 1'b0;
  assign SCL_OE_B    = ~st.m_scl_low;
  assign SDA_OE_B    = ~(st.m_sda_low | st.s_sda_low);
  assign BOOT_DONE_N = ~st.done;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  fetch_hold_a: assert property ((st.mst == sbc_pkg::M_WAIT &&
    BOOT_FETCH_ALLOW_N) |=> st.mst == sbc_pkg::M_WAIT && SCL_OE_B)
    else $error("fetch started without permission");
  fetch_go_a: assert property ((st.mst == sbc_pkg::M_WAIT &&
    !BOOT_FETCH_ALLOW_N) |=> st.mst == sbc_pkg::M_START)
    else $error("fetch did not start");
  done_hold_a: assert property (!BOOT_DONE_N |=> !BOOT_DONE_N)
    else $error("boot done released");
  done_cause_a: assert property ($fell(BOOT_DONE_N) |->
    $past(st.mst) == sbc_pkg::M_STOP)
    else $error("boot done without fetch end");
  bus_release_a: assert property (st.mst == sbc_pkg::M_DONE |=>
    SCL_OE_B && !st.m_sda_low)
    else $error("master still drives after fetch");
  strap_hold_a: assert property (st.latched |=>
    $stable(st.adr) && $stable(st.mode))
    else $error("straps changed after latch");
  addr_ack_a: assert property ((slave_on && st.sl == sbc_pkg::SL_ADDR &&
    lin.scl_fall && !lin.start_seen && !lin.stop_seen &&
    st.scnt == 4'h8 && st.ssh[7:1] ==
    7'((`SBC_WR_ADDR_BASE + {5'h00, st.adr, 1'b0}) >> 1)) |=>
    !SDA_OE_B && st.srd == $past(st.ssh[0]))
    else $error("own address not acknowledged");
  page_wr_a: assert property ((st.wr_en && st.wr_a == `SBC_PAGE_ADDR) |=>
    st.page == $past(st.wr_d) && mem_if.we_mask == 5'h00)
    else $error("page select not written");
  shared_route_a: assert property ((st.wr_en &&
    st.wr_a != `SBC_PAGE_ADDR && !st.page[2]) |->
    mem_if.we_mask == 5'h01)
    else $error("shared write misrouted");
  chan_route_a: assert property ((st.wr_en && st.wr_a != `SBC_PAGE_ADDR &&
    st.page[2] && !st.page[3]) |-> $onehot(mem_if.we_mask) &&
    mem_if.we_mask[st.page[1:0] + 2'h1 == 2'h0 ? 4 :
    int'(st.page[1:0]) + 1])
    else $error("channel write misrouted");
  bcast_a: assert property ((st.wr_en && st.wr_a != `SBC_PAGE_ADDR &&
    st.page[3] && st.page[2]) |-> mem_if.we_mask == 5'h1e)
    else $error("broadcast write misrouted");

endmodule // sbc_top

// ===== sbc_ee_model.sv
`timescale 1ns/1ps

// boot memory stand-in; a released data line reads high
module sbc_ee_model #(
  parameter logic [7:0] REG_A  = 8'hff,
  parameter logic [7:0] DATA_A = 8'h0c
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_rel
);
  logic [7:0] b;
  logic       go;

  // byte in on rising bus clock, msb first
  task automatic rx;
    repeat (8) @(posedge scl) b = {b[6:0], sda};
  endtask

  // pull data low over the ack slot
  task automatic ack;
    @(negedge scl) #1 sda_rel = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////
  // untimed bus clock handling, so fast boot clocks are kept
  initial sda_rel = 1'b1;
  always begin
    @(negedge sda iff scl === 1'b1);
    rx();
    if (b[7:1] == 7'h50) begin
      ack();
      if (!b[0]) begin
        @(negedge scl) #1 sda_rel = 1'b1;
        rx();
        ack();
        @(negedge scl) #1 sda_rel = 1'b1;
      end else begin
        go = 1'b1;
        for (int j = 0; go; j++) begin
          for (int i = 7; i >= 0; i--)
            @(negedge scl) #1 sda_rel = j[0] ? DATA_A[i] : REG_A[i];
          @(negedge scl) #1 sda_rel = 1'b1;
          @(posedge scl) go = !sda;
        end
      end
    end
  end
endmodule // sbc_ee_model

// ===== sbc_top_bench.sv
`timescale 1ns/1ps

module sbc_top_bench;
  logic       REF_CLK;
  logic       RST_B;
  logic [1:0] CONTROL_MODE_STRAP;
  logic [1:0] ADDR_STRAP;
  logic       BOOT_FETCH_ALLOW_N;
  wire        BOOT_DONE_N;
  wire        SCL_O;
  wire        SCL_OE_B;
  wire        SDA_O;
  wire        SDA_OE_B;
  wire        scl;
  wire        sda;
  logic       h_scl;
  logic       h_sda;
  wire        ee_sda;
  logic       pulled;
  logic [7:0] exp_q[$];
  logic [7:0] seen_v;
  logic [7:0] rd;
  logic [7:0] dev;
  logic [7:0] v0;
  logic [7:0] v1;
  logic [1:0] st;
  int         mismatches;
  int         check_count;
  event       got;

  // open-drain wires from every party
  assign scl = (SCL_OE_B ? 1'b1 : SCL_O) & h_scl;
  assign sda = (SDA_OE_B ? 1'b1 : SDA_O) & h_sda & ee_sda;

  sbc_top #(.BOOT_PAIRS(1)) u_sbc_top (
    .REF_CLK            (REF_CLK),
    .RST_B              (RST_B),
    .CONTROL_MODE_STRAP (CONTROL_MODE_STRAP),
    .ADDR_STRAP         (ADDR_STRAP),
    .BOOT_FETCH_ALLOW_N (BOOT_FETCH_ALLOW_N),
    .BOOT_DONE_N        (BOOT_DONE_N),
    .SCL_I              (scl),
    .SCL_O              (SCL_O),
    .SCL_OE_B           (SCL_OE_B),
    .SDA_I              (sda),
    .SDA_O              (SDA_O),
    .SDA_OE_B           (SDA_OE_B)
  );

  sbc_ee_model u_sbc_ee_model (
    .scl     (scl),
    .sda     (sda),
    .sda_rel (ee_sda)
  );

  //////////////////////////////////////////////////////////////////
  // clock, bus clock hold watch, result checker
  always #50 REF_CLK = ~REF_CLK;

  always @(posedge REF_CLK) if (!SCL_OE_B) pulled <= 1'b1;

  always @(got) check(seen_v, exp_q.pop_front());

  task automatic check(input logic [7:0] v, input logic [7:0] e);
    check_count++;
    if (v !== e) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, v, e);
    end
  endtask

  // note the expectation, then publish the result
  task automatic obs(input logic [7:0] e, input logic [7:0] v);
    exp_q.push_back(e);
    seen_v = v;
    -> got;
    hc(1);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////
  // host bus cycles, four clocks high and five clocks low per bus clock
  task automatic hc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  task automatic h_start;
    h_sda <= 1'b1;
    hc(4);
    h_scl <= 1'b1;
    hc(4);
    h_sda <= 1'b0;
    hc(4);
    h_scl <= 1'b0;
    hc(1);
  endtask

  task automatic h_stop;
    h_sda <= 1'b0;
    hc(4);
    h_scl <= 1'b1;
    hc(4);
    h_sda <= 1'b1;
    hc(4);
  endtask

  // eight bits plus ack slot; hb is the host ack level
  task automatic h_byte(input logic [7:0] d, input logic hb, input logic ea);
    logic [8:0] o;
    logic [8:0] s;
    o = {d, hb};
    for (int i = 8; i >= 0; i--) begin
      h_sda <= o[i];
      hc(4);
      h_scl <= 1'b1;
      hc(2);
      s[i] = sda;
      hc(2);
      h_scl <= 1'b0;
      hc(1);
    end
    rd = s[8:1];
    obs({7'h00, ea}, {7'h00, s[0]});
  endtask

  task automatic h_write(input logic [7:0] w, r, d);
    h_start();
    h_byte(w, 1'b1, 1'b0);
    h_byte(r, 1'b1, 1'b0);
    h_byte(d, 1'b1, 1'b0);
    h_stop();
  endtask

  task automatic h_read(input logic [7:0] w, r, e);
    h_start();
    h_byte(w, 1'b1, 1'b0);
    h_byte(r, 1'b1, 1'b0);
    h_start();
    h_byte(w | 8'h01, 1'b1, 1'b0);
    h_byte(8'hff, 1'b1, 1'b1);
    obs(e, rd);
    h_stop();
  endtask

  // reset, then flip the address strap once it is latched
  task automatic do_reset(input logic [1:0] m, input logic [1:0] s);
    RST_B <= 1'b0;
    CONTROL_MODE_STRAP <= m;
    ADDR_STRAP <= s;
    hc(4);
    RST_B <= 1'b1;
    hc(2);
    ADDR_STRAP <= ~s;
    hc(2);
  endtask

  //////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    hc(60000);
    mismatches++;
    close_out();
  end

  // main sequence
  initial begin
    REF_CLK = 1'b0;
    RST_B = 1'b0;
    h_scl = 1'b1;
    h_sda = 1'b1;
    pulled = 1'b0;
    BOOT_FETCH_ALLOW_N = 1'b1;
    CONTROL_MODE_STRAP = sbc_pkg::MODE_BOOT;
    ADDR_STRAP = 2'h0;
    void'($urandom(32'h4bff_9adb));
    st = 2'($urandom());
    v0 = 8'($urandom());
    v1 = 8'($urandom());
    do_reset(sbc_pkg::MODE_BOOT, st);
    hc(300);
    obs(8'h00, {7'h00, pulled});
    obs(8'h01, {7'h00, BOOT_DONE_N});
    BOOT_FETCH_ALLOW_N <= 1'b0;
    for (int n = 0; n < 5000 && BOOT_DONE_N !== 1'b0; n++) hc(1);
    pulled <= 1'b0;
    hc(1);
    obs(8'h00, {7'h00, BOOT_DONE_N});
    dev = 8'h30 + {5'h00, st, 1'b0};
    h_read(dev, 8'hff, 8'h0c);
    h_write(dev, 8'h00, v0);
    h_write(dev, 8'hff, 8'h07);
    h_read(dev, 8'h00, v0);
    h_write(dev, 8'hff, 8'h04);
    h_write(dev, 8'h00, v1);
    h_read(dev, 8'h00, v1);
    h_read(dev, 8'hff, 8'h04);
    h_write(dev, 8'hff, rd | 8'h01);
    h_read(dev, 8'h00, v0);
    h_write(dev, 8'hff, 8'h00);
    h_write(dev, 8'h00, ~v0);
    h_read(dev, 8'h00, ~v0);
    h_write(dev, 8'hff, 8'h04);
    h_read(dev, 8'h00, v1);
    h_start();
    h_byte(dev ^ 8'h02, 1'b1, 1'b1);
    h_stop();
    obs(8'h00, {7'h00, pulled});
    obs(8'h00, {7'h00, BOOT_DONE_N});
    do_reset(sbc_pkg::MODE_PIN, 2'h0);
    h_start();
    h_byte(8'h30, 1'b1, 1'b1);
    h_stop();
    for (int s = 0; s < 4; s++) begin
      BOOT_FETCH_ALLOW_N <= 1'b0;
      do_reset(sbc_pkg::MODE_SLAVE, 2'(s));
      dev = 8'h30 + 8'(2 * s);
      h_write(dev, 8'hff, 8'(s + 8));
      h_read(dev, 8'hff, 8'(s + 8));
    end
    close_out();
  end
endmodule // sbc_top_bench
